// *** hss_side_ctrl.sv ***
// Hot standby side control: role, changeover, host gating, termination
`include "hss_defs.svh"
`default_nettype none
module hss_side_ctrl #(
    parameter int unsigned HOLD_CYC = `HSS_HOLD_CYC,
    parameter int unsigned FLASH_CYC = `HSS_FLASH_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Peer side status and start-up strap
    input wire logic peer_power_ok,
    input wire logic peer_is_primary,
    input wire logic start_primary,
    // Front panel
    input wire logic primary_btn,
    output logic primary_led,
    // Host link health
    input wire logic net_plugged,
    input wire logic net_traffic_lost,
    input wire logic [1:0] ser_traffic_lost,
    // Host messages: index 0 network, 1 and 2 serial
    input wire logic [2:0] host_msg,
    input wire logic [2:0] host_is_switch,
    output logic [2:0] host_reply_en,
    output logic [2:0] host_exec_en,
    // Roles and field control
    output logic is_primary,
    output logic field_drive_en,
    output logic swap_pulse,
    // Serial termination
    output logic [1:0] term_en
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    hss_pkg::hss_role_t role_r; // Current role of this side
    logic [31:0] ctrl_r; // Response settings and trigger enables
    logic [1:0] term_r; // Per-port termination enable
    logic ui_req_r; // Software switch request, one cycle
    logic swap_r; // Changeover pulse, registered
    logic [31:0] flash_cnt_r; // Indicator flash divider
    logic flash_r; // Indicator flash phase
    logic [31:0] rdata_r; // Read data register
    logic ack_r; // Bus answer phase
    logic strap_done_r; // Start-up role taken
    logic net_plugged_r; // Previous plug state
    logic press_p; // Short button press
    logic hold_p; // Three second hold
    logic forced; // Forced primary active
    logic prim; // Primary or forced
    logic [2:0] resp_set; // Per-port responding setting
    logic host_switch; // Switch accepted from a host
    logic link_trig; // Optional link-loss trigger
    logic trig; // Any accepted changeover trigger
    logic bus_req; // Bus access present
    logic peer_fail; // Peer lost power while this side is standby

    // ----------------------------------------
    // Button hold detection
    // ----------------------------------------
    hss_hold_timer #(
        .HOLD_CYC(HOLD_CYC)
    ) u_hold (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .btn(primary_btn),
        .press_pulse(press_p),
        .hold_pulse(hold_p)
    );

    assign forced = (role_r == hss_pkg::HSS_ROLE_FORCED);
    assign prim = (role_r != hss_pkg::HSS_ROLE_STANDBY);

    // ----------------------------------------
    // Host message gating
    // ----------------------------------------
    // Network ports share one setting, serial ports own one each
    assign resp_set[0] = ctrl_r[`HSS_CTRL_NET_RESP];
    assign resp_set[1] = ctrl_r[`HSS_CTRL_SER0_RESP];
    assign resp_set[2] = ctrl_r[`HSS_CTRL_SER1_RESP];

    // Reply and execute permission per port
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            // Primary answers all; responding standby answers; silent standby is mute
            host_reply_en[i] = host_msg[i] && (prim || resp_set[i]);
            if (prim) begin
                host_exec_en[i] = host_msg[i];
            end else if (resp_set[i]) begin
                host_exec_en[i] = host_msg[i] && host_is_switch[i];
            end else begin
                // Silent standby: switch accepted from serial only
                host_exec_en[i] = host_msg[i] && host_is_switch[i] && (i != 0);
            end
        end
    end

    // Any permitted switch from any port, no port ranks above another
    assign host_switch = |(host_exec_en & host_is_switch);

    // ----------------------------------------
    // Changeover triggers
    // ----------------------------------------
    // Optional link triggers only matter on the primary side
    assign link_trig = prim && (
        (ctrl_r[`HSS_CTRL_EN_NETPLUG] && net_plugged_r && !net_plugged) ||
        (ctrl_r[`HSS_CTRL_EN_NETIDLE] && net_traffic_lost) ||
        (ctrl_r[`HSS_CTRL_EN_SERIDLE] && |ser_traffic_lost));

    // Peer power loss makes the standby take over
    // A primary side that loses its peer keeps its role: there is nothing to hand over
    assign peer_fail = !prim && !peer_power_ok;

    // Forced mode blocks every trigger other than the hold
    assign trig = !forced && (host_switch || ui_req_r || press_p || link_trig || peer_fail);

    // Plug edge memory
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            net_plugged_r <= 1'b0;
        end else begin
            net_plugged_r <= net_plugged;
        end
    end

    // ----------------------------------------
    // Role state
    // ----------------------------------------
    // Role swaps in one edge; the peer sees our change and inverts
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            role_r <= hss_pkg::HSS_ROLE_STANDBY;
            strap_done_r <= 1'b0;
            swap_r <= 1'b0;
        end else begin
            swap_r <= 1'b0;
            if (!strap_done_r) begin
                // Start-up role from strap, unless the peer already leads
                strap_done_r <= 1'b1;
                role_r <= (start_primary && !peer_is_primary) ?
                    hss_pkg::HSS_ROLE_PRIMARY : hss_pkg::HSS_ROLE_STANDBY;
            end else begin
                case (role_r)
                    hss_pkg::HSS_ROLE_STANDBY: begin
                        if (hold_p) begin
                            role_r <= hss_pkg::HSS_ROLE_FORCED;
                            swap_r <= 1'b1;
                        end else if (trig) begin
                            role_r <= hss_pkg::HSS_ROLE_PRIMARY;
                            swap_r <= 1'b1;
                        end
                    end
                    hss_pkg::HSS_ROLE_PRIMARY: begin
                        if (hold_p) begin
                            role_r <= hss_pkg::HSS_ROLE_FORCED;
                        end else if (host_switch || ui_req_r || link_trig) begin
                            // Own button press selects this side, not a swap,
                            // and a press must never mask a link loss in the same cycle
                            role_r <= hss_pkg::HSS_ROLE_STANDBY;
                            swap_r <= 1'b1;
                        end
                    end
                    hss_pkg::HSS_ROLE_FORCED: begin
                        if (hold_p) begin
                            role_r <= hss_pkg::HSS_ROLE_PRIMARY;
                        end
                    end
                    default: begin
                        role_r <= hss_pkg::HSS_ROLE_STANDBY;
                    end
                endcase
            end
        end
    end

    // Field drive strictly tied to primary role
    assign is_primary = prim;
    assign field_drive_en = prim && strap_done_r;
    assign swap_pulse = swap_r;

    // ----------------------------------------
    // Indicator flash
    // ----------------------------------------
    // Flash divider runs only while forced
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_cnt_r <= 32'h00000000;
            flash_r <= 1'b0;
        end else if (!forced) begin
            flash_cnt_r <= 32'h00000000;
            flash_r <= 1'b0;
        end else if (flash_cnt_r == FLASH_CYC - 1) begin
            flash_cnt_r <= 32'h00000000;
            flash_r <= !flash_r;
        end else begin
            flash_cnt_r <= flash_cnt_r + 32'h00000001;
        end
    end

    // Steady when primary, flashing when forced
    assign primary_led = forced ? !flash_r : prim;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    assign bus_req = avs_read || avs_write;
    // One wait cycle, then answer
    assign avs_waitrequest = bus_req && !ack_r;

    // Answer phase toggles per access
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= bus_req && !ack_r;
        end
    end

    // Writable registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= `HSS_CTRL_RESET;
            term_r <= 2'b00;
            ui_req_r <= 1'b0;
        end else begin
            ui_req_r <= 1'b0;
            // Write lands on the answer edge, where waitrequest is low,
            // so the master's view of the access and the register agree
            if (avs_write && ack_r) begin
                case (avs_address)
                    `HSS_REG_CTRL: ctrl_r <= {26'h0000000, avs_writedata[5:0]};
                    `HSS_REG_TERM: term_r <= avs_writedata[1:0];
                    `HSS_REG_CMD: ui_req_r <= avs_writedata[0];
                    default: ;
                endcase
            end
        end
    end

    assign term_en = term_r;

    // Read data, unmapped addresses read zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 32'h00000000;
        end else if (avs_read && !ack_r) begin
            case (avs_address)
                `HSS_REG_CTRL: rdata_r <= ctrl_r;
                `HSS_REG_STAT: rdata_r <= {29'h00000000, peer_is_primary, forced, prim};
                `HSS_REG_TERM: rdata_r <= {30'h00000000, term_r};
                default: rdata_r <= 32'h00000000;
            endcase
        end
    end

    assign avs_readdata = rdata_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    field_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        field_drive_en |-> role_r != hss_pkg::HSS_ROLE_STANDBY) else $error("field drive while standby");
    term_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(strap_done_r) |-> term_en == 2'b00) else $error("termination on after reset");
    forced_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        forced && !hold_p |=> forced) else $error("forced mode left without hold");
    forced_exit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        forced && hold_p |=> role_r == hss_pkg::HSS_ROLE_PRIMARY) else $error("forced exit failed");
    silent_mute_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !prim && !resp_set[0] |-> !host_reply_en[0]) else $error("silent port replied");
    resp_reply_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        host_msg[1] && resp_set[1] |-> host_reply_en[1]) else $error("responding port mute");
    standby_cmd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !prim && |(host_exec_en & ~host_is_switch) |-> 1'b0) else $error("standby ran command");
    net_switch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !prim && !resp_set[0] |-> !host_exec_en[0]) else $error("silent net switch taken");
    swap_role_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        swap_r |-> prim != $past(prim)) else $error("swap without role change");
    flash_led_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !forced |-> primary_led == prim) else $error("led wrong outside forced");

    // ----------------------------------------
    // Multi-step checks
    // ----------------------------------------
    // A settled role change seen across one edge, start-up strap excluded
    sequence role_flip_s;
        strap_done_r && $past(strap_done_r) && (prim != $past(prim));
    endsequence
    // Hold detected outside forced mode, after start-up
    sequence hold_enter_s;
        strap_done_r && !forced && hold_p;
    endsequence
    // Flash divider at its wrap point while forced
    sequence flash_wrap_s;
        forced && (flash_cnt_r == FLASH_CYC - 1);
    endsequence
    // Plain primary side hit by an enabled link loss
    sequence link_loss_s;
        (role_r == hss_pkg::HSS_ROLE_PRIMARY) && link_trig && !hold_p;
    endsequence
    // Standby side with a dead peer and no button hold
    sequence peer_lost_s;
        strap_done_r && (role_r == hss_pkg::HSS_ROLE_STANDBY) && !peer_power_ok && !hold_p;
    endsequence
    // Edge with no write landing in the termination register
    sequence term_quiet_s;
        !(avs_write && ack_r && (avs_address == `HSS_REG_TERM));
    endsequence

    // Every change between standby and a primary role after start-up is announced by the swap pulse
    swap_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        role_flip_s |-> swap_r) else $error("role changed without swap pulse");
    // Hold enters forced mode from either plain role
    forced_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hold_enter_s |=> forced) else $error("hold did not enter forced mode");
    // Divider wrap turns the indicator over
    flash_turn_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        flash_wrap_s |=> !forced || (primary_led != $past(primary_led))) else $error("indicator did not flash");
    // Enabled link loss drops a plain primary side
    link_drop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        link_loss_s |=> !prim) else $error("link loss ignored on primary");
    // A dead peer promotes the standby side
    peer_take_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        peer_lost_s |=> prim) else $error("standby kept role after peer loss");
    // Termination moves only on its own register write
    term_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        term_quiet_s |=> $stable(term_r)) else $error("termination changed without write");
    // Primary side answers and runs every message
    primary_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        prim |-> (host_reply_en == host_msg) && (host_exec_en == host_msg)) else $error("primary dropped a message");
    // Forced mode is always a controlling primary role
    forced_prim_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        forced |-> is_primary && field_drive_en) else $error("forced side not in control");
    // Silent second serial port stays mute on standby
    silent_ser_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !prim && !resp_set[2] |-> !host_reply_en[2]) else $error("silent serial port replied");
endmodule : hss_side_ctrl
`default_nettype wire

// *** hss_defs.svh ***
// Constants for the hot standby side control block
// Contract
// - Only primary side drives field networks.
// - Exactly one side primary, other standby.
// - Each side keeps own status database.
// - Power loss, host, button, UI trigger changeover.
// - Optional link-loss triggers also cause changeover.
// - Three second hold enters forced primary.
// - Three second hold again leaves forced primary.
// - Button indicator flashes during forced primary.
// - Network ports share one standby setting.
// - Responding setting answers in either role.
// - Silent setting answers only when primary.
// - Primary answers and executes all commands.
// - Responding standby executes only switch command.
// - Silent standby switches only via serial.
// - Both hosts handled with equal weight.
// - Termination enables off after reset.
// - Termination enable held per serial port.
`ifndef HSS_DEFS_SVH
`define HSS_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HSS_REG_CTRL 4'h0
`define HSS_REG_STAT 4'h4
`define HSS_REG_TERM 4'h8
`define HSS_REG_CMD 4'hC
// ----------------------------------------
// Control fields
// ----------------------------------------
`define HSS_CTRL_NET_RESP 0
`define HSS_CTRL_SER0_RESP 1
`define HSS_CTRL_SER1_RESP 2
`define HSS_CTRL_EN_NETPLUG 3
`define HSS_CTRL_EN_NETIDLE 4
`define HSS_CTRL_EN_SERIDLE 5
`define HSS_CTRL_RESET 32'h00000000
// ----------------------------------------
// Timing
// ----------------------------------------
`define HSS_CLK_HZ 125000000
`define HSS_HOLD_MS 3000
`define HSS_HOLD_CYC ((`HSS_CLK_HZ / 1000) * `HSS_HOLD_MS)
`define HSS_FLASH_MS 250
`define HSS_FLASH_CYC ((`HSS_CLK_HZ / 1000) * `HSS_FLASH_MS)
`endif

// *** hss_pkg.sv ***
// Types for the hot standby side control block
`default_nettype none
package hss_pkg;
    // Role of this side
    typedef enum logic [1:0] {
        HSS_ROLE_STANDBY = 2'b00,
        HSS_ROLE_PRIMARY = 2'b01,
        HSS_ROLE_FORCED = 2'b10
    } hss_role_t;
endpackage : hss_pkg
`default_nettype wire

// *** hss_hold_timer.sv ***
// Press-and-hold detector for the primary button
`default_nettype none
module hss_hold_timer #(
    parameter int unsigned HOLD_CYC = 375000000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Button level and detection pulses
    input wire logic btn,
    output logic press_pulse,
    output logic hold_pulse
);
    logic [31:0] cnt_r;
    logic btn_r;
    logic fired_r;

    // Count while held, fire once per press
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 32'h00000000;
            fired_r <= 1'b0;
            btn_r <= 1'b0;
        end else begin
            btn_r <= btn;
            if (!btn) begin
                cnt_r <= 32'h00000000;
                fired_r <= 1'b0;
            end else if (!fired_r && cnt_r == HOLD_CYC - 1) begin
                fired_r <= 1'b1;
            end else if (!fired_r) begin
                cnt_r <= cnt_r + 32'h00000001;
            end
        end
    end

    // Short press reported on release before the hold fired
    assign press_pulse = btn_r && !btn && !fired_r;
    assign hold_pulse = btn && !fired_r && (cnt_r == HOLD_CYC - 1);
endmodule : hss_hold_timer
`default_nettype wire

// *** hss_host_model.sv ***
// Host control system model that sends one message at a time to the side controller
`default_nettype none
module hss_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Request from the bench
    input wire logic req_valid,
    input wire logic [1:0] req_port,
    input wire logic req_switch,
    // Message strobes toward the controller
    output logic [2:0] host_msg,
    output logic [2:0] host_is_switch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] junk_r; // Changing pattern for an unqualified qualifier
    // One-cycle message per request; qualifier is junk between messages
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_msg <= 3'h0;
            host_is_switch <= 3'h5;
            junk_r <= 3'h5;
        end else begin
            junk_r <= ~junk_r ^ {junk_r[1:0], junk_r[2]};
            host_msg <= req_valid ? (3'h1 << req_port) : 3'h0;
            host_is_switch <= req_valid ? {3{req_switch}} : junk_r;
        end
    end
endmodule : hss_host_model
`default_nettype wire

// *** hss_side_ctrl_tb.sv ***
// Self-checking bench for the hot standby side controller
`default_nettype none
module hss_side_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HOLD = 20; // Short hold so the run stays brief
    localparam int unsigned FLASH = 4; // Short flash half period
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic peer_power_ok = 1'b1;
    logic peer_is_primary = 1'b1; // Other side starts in control
    logic primary_btn = 1'b0;
    logic net_plugged = 1'b1;
    logic net_traffic_lost = 1'b0;
    logic [1:0] ser_traffic_lost = 2'h0;
    logic req_valid = 1'b0;
    logic [1:0] req_port = 2'h0;
    logic req_switch = 1'b0;
    logic [2:0] host_msg, host_is_switch, host_reply_en, host_exec_en;
    logic is_primary, field_drive_en, swap_pulse, primary_led, led0;
    logic [1:0] term_en;
    logic [31:0] rng = 32'h40A3; // Fixed xorshift seed
    logic [31:0] rd; // Last read data
    logic prim_q = 1'b0; // Role seen at the previous edge
    int n_mismatch = 0;
    int n_compared = 0;
    int n;
    hss_side_ctrl #(.HOLD_CYC(HOLD), .FLASH_CYC(FLASH)) DUT (
        .sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .peer_power_ok, .peer_is_primary, .start_primary(1'b0), .primary_btn,
        .primary_led, .net_plugged, .net_traffic_lost, .ser_traffic_lost, .host_msg, .host_is_switch,
        .host_reply_en, .host_exec_en, .is_primary, .field_drive_en, .swap_pulse, .term_en);
    hss_host_model host (.sys_clk, .sys_rst, .req_valid, .req_port, .req_switch, .host_msg, .host_is_switch);
    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    // Other side follows our role one cycle later, as a real peer would
    always @(posedge sys_clk) begin
        peer_is_primary <= sys_rst ? 1'b1 : ~is_primary;
    end
    // Every role change must come with the swap pulse launched by the same edge
    always @(posedge sys_clk) begin
        if (!sys_rst && is_primary !== prim_q) begin
            chk_bit("swap_pulse", 1'b1, swap_pulse);
        end
        prim_q <= is_primary;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    // One bus access; waits for waitrequest low with a bound
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        // Request stands until waitrequest is sampled low at a rising edge
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            $display("MISMATCH waitrequest expected 0 seen 1");
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    // Waits a bounded time for the role, then checks role and field drive
    task automatic wait_role(input logic e);
        int k;
        k = 0;
        while (is_primary !== e && k < 30) begin
            @(posedge sys_clk);
            k++;
        end
        @(negedge sys_clk);
        chk_bit("is_primary", e, is_primary);
        chk_bit("field_drive_en", e, field_drive_en);
        @(posedge sys_clk);
    endtask : wait_role
    // One host message, gating checked in its own cycle
    task automatic msg(input int p, input logic sw, input logic er, input logic ee);
        req_valid <= 1'b1;
        req_port <= 2'(p);
        req_switch <= sw;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        @(negedge sys_clk);
        chk_bit("host_reply_en", er, host_reply_en[p]);
        chk_bit("host_exec_en", ee, host_exec_en[p]);
        @(posedge sys_clk);
    endtask : msg
    task automatic press(input int cyc);
        primary_btn <= 1'b1;
        repeat (cyc) @(posedge sys_clk);
        primary_btn <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : press
    // Link loss: 0 unplug, 1 network idle, 2 serial idle on port b
    task automatic lose(input int k, input logic b, input logic on);
        net_plugged <= !(on && k == 0);
        net_traffic_lost <= on && k == 1;
        ser_traffic_lost <= (on && k == 2) ? (2'h1 << b) : 2'h0;
    endtask : lose
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // Hang guard, far beyond the expected few hundred cycles
    initial begin
        #(8 * 20000);
        n_mismatch++;
        $display("MISMATCH watchdog expected done seen timeout");
        complete_run();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        chk_word("term_en reset", 32'h0, {30'h0, term_en});
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk_word("term_en after reset", 32'h0, {30'h0, term_en});
        wait_role(1'b0);
        // Every termination pattern, junk in the upper bits
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            bus(1'b1, 4'h8, {rng[31:2], 2'(i)});
            chk_word("term_en", 32'(i), {30'h0, term_en});
            bus(1'b0, 4'h8, 32'h0);
            chk_word("term read", 32'(i), {30'h0, rd[1:0]});
        end
        bus(1'b1, 4'h2, rng);
        bus(1'b0, 4'h2, 32'h0);
        chk_word("unmapped read", 32'h0, rd);
        bus(1'b0, 4'h4, 32'h0);
        chk_word("stat primary", 32'h0, {31'h0, rd[0]});
        $display("test registers done");
        // Standby gating per port and setting, then switch command
        for (int p = 0; p < 3; p++) begin
            for (int r = 0; r < 2; r++) begin
                rng = xs(rng);
                bus(1'b1, 4'h0, {26'h0, rng[5:3], {3{r[0]}}});
                msg(p, 1'b0, r[0], 1'b0);
                msg(p, 1'b1, r[0], r[0] | (p != 0));
                wait_role(r[0] | (p != 0));
                if (is_primary === 1'b1) begin
                    msg(p, 1'b0, 1'b1, 1'b1);
                    bus(1'b1, 4'hC, 32'h1);
                    wait_role(1'b0);
                end
            end
        end
        $display("test host gating done");
        // Link loss triggers, disabled then enabled
        for (int k = 0; k < 3; k++) begin
            for (int en = 0; en < 2; en++) begin
                if (is_primary !== 1'b1) begin
                    press(3);
                    wait_role(1'b1);
                end
                bus(1'b1, 4'h0, 32'h7 | (32'(en) << (3 + k)));
                rng = xs(rng);
                lose(k, rng[0], 1'b1);
                repeat (8) @(posedge sys_clk);
                wait_role(en == 0);
                lose(k, rng[0], 1'b0);
            end
        end
        // Peer power loss promotes this standby side
        peer_power_ok <= 1'b0;
        wait_role(1'b1);
        peer_power_ok <= 1'b1;
        $display("test link triggers done");
        // Forced primary: entry, flashing, immunity, exit
        press(HOLD + 4);
        wait_role(1'b1);
        bus(1'b0, 4'h4, 32'h0);
        chk_word("stat forced", 32'h1, {31'h0, rd[1]});
        n = 0;
        led0 = primary_led;
        repeat (4 * FLASH) begin
            @(posedge sys_clk);
            if (primary_led !== led0) n++;
            led0 = primary_led;
        end
        chk_bit("led flashing", 1'b1, n >= 2);
        bus(1'b1, 4'hC, 32'h1);
        lose(2, 1'b0, 1'b1);
        repeat (10) @(posedge sys_clk);
        wait_role(1'b1);
        lose(2, 1'b0, 1'b0);
        press(HOLD + 4);
        bus(1'b0, 4'h4, 32'h0);
        chk_word("stat forced", 32'h0, {31'h0, rd[1]});
        bus(1'b1, 4'hC, 32'h1);
        wait_role(1'b0);
        $display("test forced primary done");
        complete_run();
    end
endmodule : hss_side_ctrl_tb
`default_nettype wire
